// [verilog/ddr_init_pkg.sv]
// Shared constants, commands and states for DRAM init and mode setup
package ddr_init_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int PWRUP_WAIT_NS = 200000;
    localparam int PRECHARGE_WAIT_NS = 20;
    localparam int MODE_SET_WAIT_NS = 15;
    localparam int REFRESH_CYCLE_WAIT_NS = 120;
    localparam int DLL_LOCK_CYC = 200;

    // Least time to whole cycles, never below one
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int PWRUP_CYC = cyc_up(PWRUP_WAIT_NS);
    localparam int PRECHARGE_CYC = cyc_up(PRECHARGE_WAIT_NS);
    localparam int MODE_SET_CYC = cyc_up(MODE_SET_WAIT_NS);
    localparam int REFRESH_CYC = cyc_up(REFRESH_CYCLE_WAIT_NS);

    // ------------------------------------------------------------
    // Pins and commands {cs_n, ras_n, cas_n, we_n}
    // ------------------------------------------------------------
    localparam int ADDR_W = 14;
    localparam int DQ_W = 8;
    localparam logic [3:0] CMD_DESEL = 4'hf;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam logic [1:0] BANK_BASE = 2'h0;
    localparam logic [1:0] BANK_EXT = 2'h1;
    localparam int AUTO_PRECHARGE_ADDR_BIT = 10;

    // ------------------------------------------------------------
    // Mode register fields
    // ------------------------------------------------------------
    localparam int BL_LSB = 0;
    localparam int BT_BIT = 3;
    localparam int CL_LSB = 4;
    localparam int MODE_LSB = 7;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] CL_2 = 3'h2;
    localparam logic [2:0] CL_2P5 = 3'h6;
    localparam logic [2:0] CL_3 = 3'h3;
    localparam logic [2:0] CL_4 = 3'h4;
    localparam logic [6:0] OPMODE_NORMAL = 7'h00;
    localparam logic [6:0] OPMODE_DLL_RESET = 7'h02;
    localparam int DLL_DIS_BIT = 0;
    localparam int DS_BIT = 1;
    localparam int EXT_MODE_LSB = 2;
    localparam logic [11:0] EXT_OPMODE_NORMAL = 12'h000;
    localparam logic [6:0] MODE_CFG_RESET = 7'h22;

    // ------------------------------------------------------------
    // Controller register port
    // ------------------------------------------------------------
    localparam int RADDR_W = 4;
    localparam int RDATA_W = 16;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_MODE = 4'h1;
    localparam logic [3:0] REG_EXT = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam int CTRL_START_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_READY_BIT = 1;
    localparam int STAT_STATE_LSB = 8;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h00,
        ST_PWRUP = 5'h01,
        ST_CKE_NOP = 5'h02,
        ST_PRE1 = 5'h03,
        ST_WAIT_RP1 = 5'h04,
        ST_EMRS = 5'h05,
        ST_WAIT_MRD1 = 5'h06,
        ST_MRS_RST = 5'h07,
        ST_WAIT_MRD2 = 5'h08,
        ST_PRE2 = 5'h09,
        ST_WAIT_RP2 = 5'h0a,
        ST_REF1 = 5'h0b,
        ST_WAIT_RFC1 = 5'h0c,
        ST_REF2 = 5'h0d,
        ST_WAIT_RFC2 = 5'h0e,
        ST_MRS_CLR = 5'h0f,
        ST_WAIT_MRD3 = 5'h10,
        ST_DLL_WAIT = 5'h11,
        ST_READY = 5'h12
    } init_state_e;

endpackage

// [verilog/ddr_cmd_if.sv]
// Command, address and data pins between controller and DRAM
`timescale 1ns/1ps
interface ddr_cmd_if;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bank;
    logic [ddr_init_pkg::ADDR_W-1:0] addr;
    logic [ddr_init_pkg::DQ_W-1:0] dq_o;
    logic dq_oe;
    logic dqs_o;
    logic dqs_oe;

    modport ctrl (
        output cke, cs_n, ras_n, cas_n, we_n, bank, addr,
        input dq_o, dq_oe, dqs_o, dqs_oe
    );
    modport dram (
        input cke, cs_n, ras_n, cas_n, we_n, bank, addr,
        output dq_o, dq_oe, dqs_o, dqs_oe
    );
endinterface

// [verilog/ddr_init_ctrl.sv]
// Controller end: power-up and mode setup sequencer with register port
// What this block and ddr_mode_dram do
// - Hold clock enable low during power-up
// - Wait 200 us after stable clock
// - Raise clock enable, then idle commands
// - Precharge all, then precharge wait
// - Write extended register, DLL enabled, wait
// - Write base register with DLL reset, wait
// - Second precharge all, then precharge wait
// - Two refreshes, each with refresh wait
// - Write base register, DLL reset cleared
// - 200 high-enable cycles after DLL reset
// - Burst length codes 2, 4, 8
// - Bit 3 picks sequential or interleaved
// - CAS latency codes in bits 6..4
// - Operating mode: normal or DLL reset
// - Burst order from length, type, start
// - Sequential adds, interleaved XORs step count
// - Low column bits pick first access
// - Burst wraps inside its aligned block
// - Extended bit0 DLL, bit1 drive strength
// - Extended bits 13..2 written as zero
// - Bank bits select base or extended
// - Precharge with address bit 10 closes all
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module ddr_init_ctrl #(
    parameter int PWRUP_CYC = ddr_init_pkg::PWRUP_CYC
) (
    input wire logic mclk,
    input wire logic resetn,
    ddr_cmd_if.ctrl mem,
    input wire logic [ddr_init_pkg::RADDR_W-1:0] reg_addr,
    input wire logic [ddr_init_pkg::RDATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [ddr_init_pkg::RDATA_W-1:0] reg_rdata,
    output logic init_done
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        ddr_init_pkg::init_state_e st;
        logic [13:0] cnt;
        logic [7:0] dll_cnt;
        logic cke;
        logic [3:0] cmd;
        logic [1:0] bank;
        logic [13:0] addr;
        logic [6:0] mode_cfg;
        logic ds;
        logic [15:0] rdata;
    } ctl_s;

    ctl_s q;
    ctl_s d;

    localparam logic [13:0] PWRUP_LOAD = 14'(PWRUP_CYC - 1);
    localparam logic [13:0] RP_LOAD = 14'(ddr_init_pkg::PRECHARGE_CYC - 1);
    localparam logic [13:0] MRD_LOAD = 14'(ddr_init_pkg::MODE_SET_CYC - 1);
    localparam logic [13:0] RFC_LOAD = 14'(ddr_init_pkg::REFRESH_CYC - 1);
    localparam logic [7:0] DLL_LOAD = 8'(ddr_init_pkg::DLL_LOCK_CYC);

    // Where a finished wait goes next
    function automatic ddr_init_pkg::init_state_e after_wait(
        input ddr_init_pkg::init_state_e s);
        ddr_init_pkg::init_state_e n;
        n = ddr_init_pkg::ST_IDLE;
        unique case (s)
            ddr_init_pkg::ST_PWRUP: n = ddr_init_pkg::ST_CKE_NOP;
            ddr_init_pkg::ST_WAIT_RP1: n = ddr_init_pkg::ST_EMRS;
            ddr_init_pkg::ST_WAIT_MRD1: n = ddr_init_pkg::ST_MRS_RST;
            ddr_init_pkg::ST_WAIT_MRD2: n = ddr_init_pkg::ST_PRE2;
            ddr_init_pkg::ST_WAIT_RP2: n = ddr_init_pkg::ST_REF1;
            ddr_init_pkg::ST_WAIT_RFC1: n = ddr_init_pkg::ST_REF2;
            ddr_init_pkg::ST_WAIT_RFC2: n = ddr_init_pkg::ST_MRS_CLR;
            ddr_init_pkg::ST_WAIT_MRD3: n = ddr_init_pkg::ST_DLL_WAIT;
            default: n = ddr_init_pkg::ST_IDLE;
        endcase
        return n;
    endfunction

    logic start;
    logic [13:0] base_word;

    assign start = reg_wr && (reg_addr == ddr_init_pkg::REG_CTRL)
        && reg_wdata[ddr_init_pkg::CTRL_START_BIT];
    assign base_word = {ddr_init_pkg::OPMODE_NORMAL, q.mode_cfg};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.cmd = ddr_init_pkg::CMD_NOP;
        d.bank = '0;
        d.addr = '0;
        d.rdata = '0;
        if (q.cke && q.dll_cnt != 8'h00) begin
            d.dll_cnt = q.dll_cnt - 8'h01;
        end
        if (reg_wr && reg_addr == ddr_init_pkg::REG_MODE) begin
            d.mode_cfg = reg_wdata[6:0];
        end
        if (reg_wr && reg_addr == ddr_init_pkg::REG_EXT) begin
            d.ds = reg_wdata[ddr_init_pkg::DS_BIT];
        end
        if (reg_rd) begin
            unique case (reg_addr)
                ddr_init_pkg::REG_MODE: d.rdata = {9'h000, q.mode_cfg};
                ddr_init_pkg::REG_EXT: d.rdata = {14'h0000, q.ds, 1'b0};
                ddr_init_pkg::REG_STATUS: begin
                    d.rdata[ddr_init_pkg::STAT_BUSY_BIT] =
                        (q.st != ddr_init_pkg::ST_IDLE)
                        && (q.st != ddr_init_pkg::ST_READY);
                    d.rdata[ddr_init_pkg::STAT_READY_BIT] =
                        (q.st == ddr_init_pkg::ST_READY);
                    d.rdata[ddr_init_pkg::STAT_STATE_LSB +: 5] = q.st;
                end
                default: d.rdata = '0;
            endcase
        end
        unique case (q.st)
            ddr_init_pkg::ST_IDLE, ddr_init_pkg::ST_READY: begin
                if (start) begin
                    d.st = ddr_init_pkg::ST_PWRUP;
                    d.cke = 1'b0;
                    d.cnt = PWRUP_LOAD;
                    d.dll_cnt = '0;
                end
                if (start || q.st == ddr_init_pkg::ST_IDLE) begin
                    d.cmd = ddr_init_pkg::CMD_DESEL;
                end
            end
            ddr_init_pkg::ST_PWRUP, ddr_init_pkg::ST_WAIT_RP1,
            ddr_init_pkg::ST_WAIT_MRD1, ddr_init_pkg::ST_WAIT_MRD2,
            ddr_init_pkg::ST_WAIT_RP2, ddr_init_pkg::ST_WAIT_RFC1,
            ddr_init_pkg::ST_WAIT_RFC2, ddr_init_pkg::ST_WAIT_MRD3: begin
                if (q.st == ddr_init_pkg::ST_PWRUP) begin
                    d.cmd = ddr_init_pkg::CMD_DESEL;
                end
                if (q.cnt == 14'h0000) begin
                    d.st = after_wait(q.st);
                end else begin
                    d.cnt = q.cnt - 14'h0001;
                end
            end
            ddr_init_pkg::ST_CKE_NOP: begin
                d.cke = 1'b1;
                d.st = ddr_init_pkg::ST_PRE1;
            end
            ddr_init_pkg::ST_PRE1, ddr_init_pkg::ST_PRE2: begin
                d.cmd = ddr_init_pkg::CMD_PRE;
                d.addr[ddr_init_pkg::AUTO_PRECHARGE_ADDR_BIT] = 1'b1;
                d.cnt = RP_LOAD;
                d.st = (q.st == ddr_init_pkg::ST_PRE1)
                    ? ddr_init_pkg::ST_WAIT_RP1 : ddr_init_pkg::ST_WAIT_RP2;
            end
            ddr_init_pkg::ST_EMRS: begin
                d.cmd = ddr_init_pkg::CMD_MRS;
                d.bank = ddr_init_pkg::BANK_EXT;
                d.addr = {ddr_init_pkg::EXT_OPMODE_NORMAL, q.ds, 1'b0};
                d.cnt = MRD_LOAD;
                d.st = ddr_init_pkg::ST_WAIT_MRD1;
            end
            ddr_init_pkg::ST_MRS_RST: begin
                d.cmd = ddr_init_pkg::CMD_MRS;
                d.bank = ddr_init_pkg::BANK_BASE;
                d.addr = {ddr_init_pkg::OPMODE_DLL_RESET, q.mode_cfg};
                d.dll_cnt = DLL_LOAD;
                d.cnt = MRD_LOAD;
                d.st = ddr_init_pkg::ST_WAIT_MRD2;
            end
            ddr_init_pkg::ST_REF1, ddr_init_pkg::ST_REF2: begin
                d.cmd = ddr_init_pkg::CMD_REF;
                d.cnt = RFC_LOAD;
                d.st = (q.st == ddr_init_pkg::ST_REF1)
                    ? ddr_init_pkg::ST_WAIT_RFC1 : ddr_init_pkg::ST_WAIT_RFC2;
            end
            ddr_init_pkg::ST_MRS_CLR: begin
                d.cmd = ddr_init_pkg::CMD_MRS;
                d.bank = ddr_init_pkg::BANK_BASE;
                d.addr = base_word;
                d.cnt = MRD_LOAD;
                d.st = ddr_init_pkg::ST_WAIT_MRD3;
            end
            ddr_init_pkg::ST_DLL_WAIT: begin
                if (q.dll_cnt == 8'h00) begin
                    d.st = ddr_init_pkg::ST_READY;
                end
            end
            default: d.st = ddr_init_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            q <= '{st: ddr_init_pkg::ST_IDLE, cnt: 14'h0000, dll_cnt: 8'h00,
                cke: 1'b0, cmd: ddr_init_pkg::CMD_DESEL, bank: 2'h0,
                addr: 14'h0000, mode_cfg: ddr_init_pkg::MODE_CFG_RESET,
                ds: 1'b0, rdata: 16'h0000};
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign mem.cke = q.cke;
    assign mem.cs_n = q.cmd[3];
    assign mem.ras_n = q.cmd[2];
    assign mem.cas_n = q.cmd[1];
    assign mem.we_n = q.cmd[0];
    assign mem.bank = q.bank;
    assign mem.addr = q.addr;
    assign reg_rdata = q.rdata;
    assign init_done = (q.st == ddr_init_pkg::ST_READY);

endmodule // ddr_init_ctrl

// [verilog/ddr_mode_dram.sv]
// DRAM end: mode registers, DLL reset timing and burst column order
`timescale 1ns/1ps
module ddr_mode_dram (
    input wire logic mclk,
    input wire logic resetn,
    ddr_cmd_if.dram mem,
    input wire logic burst_start,
    input wire logic [ddr_init_pkg::ADDR_W-1:0] start_col,
    output logic [ddr_init_pkg::ADDR_W-1:0] burst_col,
    output logic burst_col_valid,
    output logic [2:0] burst_length_field,
    output logic burst_order_type,
    output logic [2:0] cas_latency_field,
    output logic drive_strength_bit,
    output logic dll_enabled,
    output logic dll_locked,
    output logic all_banks_closed,
    output logic mode_reserved
);

    typedef struct packed {
        logic [13:0] base;
        logic [13:0] ext;
        logic [7:0] dll_cnt;
        logic [3:0] step;
        logic active;
        logic [13:0] start;
        logic [13:0] col;
        logic valid;
        logic prech;
    } dram_s;

    dram_s q;
    dram_s d;

    // Burst length from code, zero for reserved codes
    function automatic logic [3:0] burst_len(input logic [2:0] code);
        unique case (code)
            ddr_init_pkg::BL_2: return 4'h2;
            ddr_init_pkg::BL_4: return 4'h4;
            ddr_init_pkg::BL_8: return 4'h8;
            default: return 4'h0;
        endcase
    endfunction

    // Column of a burst step, wrapped inside its aligned block
    function automatic logic [13:0] step_col(input logic [13:0] s,
        input logic [3:0] n, input logic il, input logic [2:0] mask);
        logic [2:0] off;
        off = il ? (s[2:0] ^ n[2:0]) : (s[2:0] + n[2:0]);
        return {s[13:3], (s[2:0] & ~mask) | (off & mask)};
    endfunction

    logic cmd_ok;
    logic [3:0] cmd;
    logic [3:0] len;
    logic cl_ok;

    assign cmd_ok = mem.cke && !mem.cs_n;
    assign cmd = {mem.cs_n, mem.ras_n, mem.cas_n, mem.we_n};
    assign len = burst_len(q.base[ddr_init_pkg::BL_LSB +: 3]);

    always_comb begin
        d = q;
        d.prech = 1'b0;
        d.valid = 1'b0;
        if (mem.cke && q.dll_cnt != 8'h00) begin
            d.dll_cnt = q.dll_cnt - 8'h01;
        end
        if (cmd_ok && cmd == ddr_init_pkg::CMD_MRS) begin
            if (mem.bank == ddr_init_pkg::BANK_BASE) begin
                d.base = mem.addr;
                if (mem.addr[13:ddr_init_pkg::MODE_LSB]
                    == ddr_init_pkg::OPMODE_DLL_RESET) begin
                    d.dll_cnt = 8'(ddr_init_pkg::DLL_LOCK_CYC);
                end
            end else if (mem.bank == ddr_init_pkg::BANK_EXT) begin
                d.ext = mem.addr;
            end
        end
        if (cmd_ok && cmd == ddr_init_pkg::CMD_PRE
            && mem.addr[ddr_init_pkg::AUTO_PRECHARGE_ADDR_BIT]) begin
            d.prech = 1'b1;
        end
        if (burst_start && len != 4'h0) begin
            d.start = start_col;
            d.step = 4'h0;
            d.active = 1'b1;
        end else if (q.active) begin
            d.col = step_col(q.start, q.step, q.base[ddr_init_pkg::BT_BIT],
                3'(len - 4'h1));
            d.valid = 1'b1;
            d.step = q.step + 4'h1;
            if (q.step == len - 4'h1) begin
                d.active = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_comb begin
        unique case (q.base[ddr_init_pkg::CL_LSB +: 3])
            ddr_init_pkg::CL_2, ddr_init_pkg::CL_2P5, ddr_init_pkg::CL_3,
            ddr_init_pkg::CL_4: cl_ok = 1'b1;
            default: cl_ok = 1'b0;
        endcase
    end

    assign mem.dq_o = '0;
    assign mem.dq_oe = 1'b0;
    assign mem.dqs_o = 1'b0;
    assign mem.dqs_oe = 1'b0;
    assign burst_col = q.col;
    assign burst_col_valid = q.valid;
    assign burst_length_field = q.base[ddr_init_pkg::BL_LSB +: 3];
    assign burst_order_type = q.base[ddr_init_pkg::BT_BIT];
    assign cas_latency_field = q.base[ddr_init_pkg::CL_LSB +: 3];
    assign drive_strength_bit = q.ext[ddr_init_pkg::DS_BIT];
    assign dll_enabled = !q.ext[ddr_init_pkg::DLL_DIS_BIT];
    assign dll_locked = dll_enabled && (q.dll_cnt == 8'h00);
    assign all_banks_closed = q.prech;
    assign mode_reserved = (len == 4'h0) || !cl_ok
        || ((q.base[13:ddr_init_pkg::MODE_LSB] != ddr_init_pkg::OPMODE_NORMAL)
        && (q.base[13:ddr_init_pkg::MODE_LSB]
        != ddr_init_pkg::OPMODE_DLL_RESET))
        || (q.ext[13:ddr_init_pkg::EXT_MODE_LSB]
        != ddr_init_pkg::EXT_OPMODE_NORMAL);

endmodule // ddr_mode_dram

// [testbench/ddr_init_chk.sv]
// Checker on the command link between controller and DRAM ends
`timescale 1ns/1ps
module ddr_init_chk #(
    parameter int PWRUP_CYC = 20
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] bank,
    input wire logic [ddr_init_pkg::ADDR_W-1:0] addr,
    input wire logic dq_oe,
    input wire logic dqs_oe
);
    logic [3:0] cmd;
    logic idle, pre, mrs, refr, ext;
    int low_q;
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    assign idle = cke && cmd == ddr_init_pkg::CMD_NOP;
    assign pre = cke && cmd == ddr_init_pkg::CMD_PRE;
    assign mrs = cke && cmd == ddr_init_pkg::CMD_MRS;
    assign refr = cke && cmd == ddr_init_pkg::CMD_REF;
    assign ext = mrs && bank == ddr_init_pkg::BANK_EXT;

    // Low clock-enable cycles since reset or last high
    always_ff @(posedge mclk) begin
        if (!resetn || cke) begin
            low_q <= 0;
        end else begin
            low_q <= low_q + 1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence s_gap;
        idle [*1];
    endsequence
    sequence s_rst_write;
        mrs && bank == 2'h0 && addr[13:7] == ddr_init_pkg::OPMODE_DLL_RESET;
    endsequence

    chk_dq_released:
    assert property (!cke |-> !dq_oe && !dqs_oe)
        else $error("data pins driven with clock enable low");
    chk_cke_low_desel:
    assert property (!cke |-> cs_n)
        else $error("command selected with clock enable low");
    chk_pwrup_wait:
    assert property ($rose(cke) |-> low_q >= PWRUP_CYC)
        else $error("clock enable raised too early");
    chk_cke_then_idle:
    assert property ($rose(cke) |-> idle ##1 pre)
        else $error("no idle then precharge after clock enable");
    chk_pre_all:
    assert property (pre |-> addr[10])
        else $error("precharge without all-banks bit");
    chk_pre_wait:
    assert property (pre |=> s_gap ##1 (mrs || refr))
        else $error("precharge wait broken");
    chk_mrs_wait:
    assert property (mrs |=> s_gap)
        else $error("mode set wait broken");
    chk_ref_wait:
    assert property (refr |=> idle [*5] ##1
        (refr || mrs && bank == 2'h0 && addr[13:7] == 7'h00))
        else $error("refresh wait or order broken");
    chk_ext_dll_on:
    assert property (ext |-> !addr[0] && addr[13:2] == 12'h000)
        else $error("extended write not normal with loop on");
    chk_ext_then_rst:
    assert property (ext |=> s_gap ##1 s_rst_write)
        else $error("loop reset write not after extended write");
    chk_mrs_bank:
    assert property (mrs |-> bank == 2'h0 || bank == 2'h1)
        else $error("mode set to reserved bank");
endmodule // ddr_init_chk

// [testbench/ddr_init_and_mode_config_tb_top.sv]
// Bench: init sequence, mode fields and burst column order
`timescale 1ns/1ps
module ddr_init_and_mode_config_tb_top;
    localparam int PWRUP = 20;
    logic mclk, resetn, reg_wr, reg_rd, init_done, burst_start;
    logic burst_col_valid, burst_order_type, drive_strength_bit;
    logic dll_enabled, dll_locked, all_banks_closed, mode_reserved;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [13:0] start_col, burst_col;
    logic [2:0] burst_length_field, cas_latency_field;
    logic [2:0] c3;
    int num_errors, samples_checked, cyc, t_rst, n_closed;
    logic [18:0] cmds[$];
    ddr_cmd_if mem_if();

    ddr_init_ctrl #(.PWRUP_CYC(PWRUP)) u_ddr_init_ctrl (.mclk(mclk),
        .resetn(resetn), .mem(mem_if), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .init_done(init_done));
    ddr_mode_dram u_ddr_mode_dram (.mclk(mclk), .resetn(resetn),
        .mem(mem_if), .burst_start(burst_start), .start_col(start_col),
        .burst_col(burst_col), .burst_col_valid(burst_col_valid),
        .burst_length_field(burst_length_field),
        .burst_order_type(burst_order_type),
        .cas_latency_field(cas_latency_field),
        .drive_strength_bit(drive_strength_bit), .dll_enabled(dll_enabled),
        .dll_locked(dll_locked), .all_banks_closed(all_banks_closed),
        .mode_reserved(mode_reserved));
    ddr_init_chk #(.PWRUP_CYC(PWRUP)) u_ddr_init_chk (.mclk(mclk),
        .resetn(resetn), .cke(mem_if.cke), .cs_n(mem_if.cs_n),
        .ras_n(mem_if.ras_n), .cas_n(mem_if.cas_n), .we_n(mem_if.we_n),
        .bank(mem_if.bank), .addr(mem_if.addr), .dq_oe(mem_if.dq_oe),
        .dqs_oe(mem_if.dqs_oe));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // --------------------------------------------------------------
    // Link monitor and timeout
    // --------------------------------------------------------------
    assign c3 = {mem_if.ras_n, mem_if.cas_n, mem_if.we_n};
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            $display("ERROR %0t: timeout", $time);
            num_errors++;
            test_done();
        end
        if (all_banks_closed === 1'b1) n_closed <= n_closed + 1;
        if (mem_if.cke === 1'b1 && mem_if.cs_n === 1'b0 && c3 !== 3'h7) begin
            if (c3 === 3'h0) cmds.push_back({c3, mem_if.bank, mem_if.addr});
            else cmds.push_back({c3, 2'h0, mem_if.addr & 14'h0400});
            if (c3 === 3'h0 && mem_if.addr[13:7] === 7'h02) t_rst <= cyc;
        end
    end

    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, e);
    endtask
    task automatic run_init(input logic [6:0] m);
        logic [18:0] exp[7];
        logic res;
        int i;
        exp = '{19'h20400, 19'h04002, {5'h0, 7'h02, m}, 19'h20400,
            19'h10000, 19'h10000, {5'h0, 7'h00, m}};
        res = !(m[2:0] inside {3'h1, 3'h2, 3'h3});
        res = res || !(m[6:4] inside {3'h2, 3'h6, 3'h3, 3'h4});
        wr(ddr_init_pkg::REG_MODE, {9'h0, m});
        cmds.delete();
        n_closed = 0;
        wr(ddr_init_pkg::REG_CTRL, 16'h0001);
        @(posedge mclk);
        #1;
        for (i = 0; i < 3000 && init_done !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        check(cmds.size(), 7);
        for (i = 0; i < 7; i++) check(cmds[i], exp[i]);
        check(cyc - t_rst >= 200, 1);
        check(n_closed, 2);
        check({cas_latency_field, burst_order_type, burst_length_field}, m);
        check(mode_reserved, res);
        check({drive_strength_bit, dll_enabled, dll_locked}, 3'h7);
        rd_chk(ddr_init_pkg::REG_STATUS, {3'h0, ddr_init_pkg::ST_READY, 8'h02});
    endtask
    task automatic burst(input logic [6:0] m, input logic [13:0] c);
        int n, k;
        logic [13:0] msk, e;
        n = (m[2:0] inside {3'h1, 3'h2, 3'h3}) ? 1 << m[2:0] : 0;
        msk = 14'(n - 1);
        @(posedge mclk);
        burst_start <= 1'b1;
        start_col <= c;
        @(posedge mclk);
        burst_start <= 1'b0;
        #1;
        for (k = 0; k < 4 && burst_col_valid !== 1'b1; k++) begin
            @(posedge mclk);
            #1;
        end
        check(k < 4, n > 0);
        for (k = 0; k < n; k++) begin
            e = m[3] ? c ^ 14'(k) : (c & ~msk) | ((c + 14'(k)) & msk);
            check({burst_col_valid, burst_col}, {1'b1, e});
            @(posedge mclk);
            #1;
        end
        check(burst_col_valid, 1'b0);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        logic [6:0] cfg[6];
        logic [13:0] col[6];
        cfg = '{7'h3b, 7'h21, 7'h2a, 7'h63, 7'h4b, 7'h38};
        col = '{14'h1a5, 14'h0003, 14'h2a6, 14'h3fff, 14'h0001, 14'h1a5};
        {reg_wr, reg_rd, burst_start, resetn} = 4'h0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        start_col = 14'h0000;
        {num_errors, samples_checked, cyc, t_rst, n_closed} = '0;
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        #1;
        check({mem_if.cke, init_done, mem_if.dq_oe, mem_if.dqs_oe}, 0);
        rd_chk(ddr_init_pkg::REG_STATUS, 16'h0000);
        rd_chk(ddr_init_pkg::REG_MODE, 16'h0022);
        rd_chk(4'hf, 16'h0000);
        wr(ddr_init_pkg::REG_EXT, 16'h0002);
        rd_chk(ddr_init_pkg::REG_EXT, 16'h0002);
        wr(ddr_init_pkg::REG_STATUS, 16'hffff);
        rd_chk(ddr_init_pkg::REG_STATUS, 16'h0000);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            run_init(cfg[i]);
            burst(cfg[i], col[i]);
            $display("test mode %h done", cfg[i]);
        end
        test_done();
    end
endmodule // ddr_init_and_mode_config_tb_top
